// ===== pkg/eps_regs.svh
/*
  Constants for the endpoint status and buffer access block: command
  codes, status byte field positions, reset values and bus addresses.
  Assumes inclusion by bare name from the design file.
*/
`ifndef EPS_REGS_SVH
`define EPS_REGS_SVH

// ==========================================================
// Serial bus addresses (7 bit)
`define EPS_CMD_ADDR 7'h1B
`define EPS_DATA_ADDR 7'h1A

// ==========================================================
// Command codes
`define EPS_CMD_SELECT 8'h00
`define EPS_CMD_TXSTAT 8'h40
`define EPS_CMD_EPCOND 8'h80
`define EPS_CMD_BUFFER 8'hF0
`define EPS_CMD_NONE 8'hFF
`define EPS_LAST_EP 8'h0D

// ==========================================================
// Sizes
`define EPS_NUM_EP 14
`define EPS_EP_SLOTS 16
`define EPS_BUF_BYTES 16
`define EPS_FIFO_DEPTH 16

// ==========================================================
// last_transaction_result fields
`define EPS_TS_SUCCESS 0
`define EPS_TS_ERR_LSB 1
`define EPS_TS_ERR_MSB 4
`define EPS_TS_SETUP 5
`define EPS_TS_TOGGLE 6
`define EPS_TS_OVERRUN 7
`define EPS_TS_RESET 8'h00

// ==========================================================
// endpoint_condition fields
`define EPS_EC_SETUP 2
`define EPS_EC_STALL 3
`define EPS_EC_TOGGLE 4
`define EPS_EC_FULL 5
`define EPS_EC_RESET 8'h00

`endif

// ===== pkg/eps_pkg.sv
/*
  Types for the endpoint status and buffer access block.
  Assumes nothing of its surroundings.
*/
package eps_pkg;

  // ==========================================================
  // Transaction error codes
  typedef enum logic [3:0] {
    ERR_NONE = 4'h0,
    ERR_PID_ENC = 4'h1,
    ERR_PID_UNKNOWN = 4'h2,
    ERR_UNEXPECTED = 4'h3,
    ERR_TOKEN_CRC = 4'h4,
    ERR_DATA_CRC = 4'h5,
    ERR_TIMEOUT = 4'h6,
    ERR_BABBLE = 4'h7,
    ERR_EOP = 4'h8,
    ERR_NAK = 4'h9,
    ERR_STALL = 4'hA,
    ERR_OVERFLOW = 4'hB,
    ERR_BITSTUFF = 4'hD,
    ERR_WRONG_PID = 4'hF
  } eps_err_type;

  // One transaction report from the serial engine
  typedef struct packed {
    logic valid;
    logic [3:0] ep;
    logic isIn;
    logic success;
    logic setup;
    logic toggle;
    eps_err_type err;
  } eps_evt_type;

  // Serial engine access to the endpoint buffers
  typedef struct packed {
    logic we;
    logic [3:0] ep;
    logic [3:0] addr;
    logic [7:0] wdata;
  } eps_bufreq_type;

  // Received byte on its way to the executor
  typedef struct packed {
    logic isCmd;
    logic [7:0] data;
  } eps_byte_type;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_ACK_DRV = 8'h04,
    ST_ACK_HOLD = 8'h08,
    ST_WR_BYTE = 8'h10,
    ST_RD_BYTE = 8'h20,
    ST_RD_ACK = 8'h40,
    ST_RD_NEXT = 8'h80
  } eps_state_type;

endpackage : eps_pkg

// ===== logic/eps_buffer_access.sv
/*
  Serial command interpreter for endpoint status and buffer access,
  plus the byte FIFO between the serial receiver and the executor.
  Assumes an external open-drain wire for SDA, a serial engine on
  sys_clk that reports transactions and owns stall/full state.

*/
`include "eps_regs.svh"

// ==========================================================
// Byte FIFO
module eps_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = `EPS_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wrPtr_q;
  logic [AW:0] rdPtr_q;
  logic doPush;
  logic doPop;

  assign outValid = wrPtr_q != rdPtr_q;
  assign inReady = !((wrPtr_q[AW] != rdPtr_q[AW]) &&
                     (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]));
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;
  assign outData = mem_q[rdPtr_q[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (doPush) begin
      mem_q[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (doPush) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doPop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end
endmodule : eps_fifo

// ==========================================================
// Top
module eps_buffer_access #(
  parameter logic [6:0] CMD_ADDR = `EPS_CMD_ADDR,
  parameter logic [6:0] DATA_ADDR = `EPS_DATA_ADDR
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input eps_pkg::eps_evt_type usbEvt,
  input wire logic [`EPS_NUM_EP-1:0] epStall,
  input wire logic [`EPS_NUM_EP-1:0] epFull,
  input eps_pkg::eps_bufreq_type usbBuf,
  output logic [7:0] usbBufRdData,
  output logic [`EPS_NUM_EP-1:0] epIntFlag,
  output logic [3:0] selEndpoint
);
  import eps_pkg::*;

  function automatic logic inEpRange(input logic [7:0] cmd,
                                     input logic [7:0] base);
    return (cmd >= base) && (cmd <= base + `EPS_LAST_EP);
  endfunction : inEpRange

  // ==========================================================
  // Pin synchronisers and edge detection
  logic sclMeta_q, sclSync_q, sclDly_q;
  logic sdaMeta_q, sdaSync_q, sdaDly_q;
  logic sclRise, sclFall, startSeen, stopSeen;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sclMeta_q <= 1'b1;
      sclSync_q <= 1'b1;
      sclDly_q <= 1'b1;
      sdaMeta_q <= 1'b1;
      sdaSync_q <= 1'b1;
      sdaDly_q <= 1'b1;
    end else begin
      sclMeta_q <= scl_i;
      sclSync_q <= sclMeta_q;
      sclDly_q <= sclSync_q;
      sdaMeta_q <= sda_i;
      sdaSync_q <= sdaMeta_q;
      sdaDly_q <= sdaSync_q;
    end
  end

  assign sclRise = sclSync_q && !sclDly_q;
  assign sclFall = !sclSync_q && sclDly_q;
  assign startSeen = sclSync_q && sclDly_q && sdaDly_q && !sdaSync_q;
  assign stopSeen = sclSync_q && sclDly_q && !sdaDly_q && sdaSync_q;

  // ==========================================================
  // Shared state
  eps_state_type st_q;
  logic [2:0] bitCnt_q;
  logic [7:0] shift_q;
  logic rw_q;
  logic isData_q;
  logic sdaRel_q;
  logic [7:0] lastCmd_q;
  logic [3:0] selEp_q;
  logic [3:0] ptr_q;
  logic [7:0] bufMem_q [`EPS_EP_SLOTS][`EPS_BUF_BYTES];
  logic [7:0] txStat_q [`EPS_EP_SLOTS];
  logic [`EPS_EP_SLOTS-1:0] pend_q;
  logic [`EPS_EP_SLOTS-1:0] intFlag_q;
  logic [`EPS_EP_SLOTS-1:0] epSetup_q;
  logic [`EPS_EP_SLOTS-1:0] epTog_q;
  logic [7:0] rdByte;
  logic [3:0] rdEp;
  logic rdTake;
  logic [7:0] rxByte;
  logic [6:0] rxAddr;
  logic addrHit;

  // ==========================================================
  // FIFO between receiver and executor
  eps_byte_type fifoIn, fifoOut;
  logic fifoInValid, fifoInReady, fifoOutValid, fifoOutReady;
  logic exCmd, exWrite;

  assign rxByte = {shift_q[6:0], sdaSync_q};
  assign rxAddr = shift_q[6:0];
  assign addrHit = (rxAddr == CMD_ADDR && !sdaSync_q) ||
                   (rxAddr == DATA_ADDR);
  assign fifoInValid = (st_q == ST_WR_BYTE) && sclRise &&
                       (bitCnt_q == 3'h7) && !startSeen && !stopSeen;
  assign fifoIn = '{isCmd: !isData_q, data: rxByte};

  // Engine buffer writes win the memory port; the FIFO absorbs it
  assign fifoOutReady = !usbBuf.we;
  assign exCmd = fifoOutValid && fifoOutReady && fifoOut.isCmd;
  assign exWrite = fifoOutValid && fifoOutReady && !fifoOut.isCmd &&
                   (lastCmd_q == `EPS_CMD_BUFFER);

  eps_fifo #(
    .WIDTH($bits(eps_byte_type)),
    .DEPTH(`EPS_FIFO_DEPTH)
  ) eps_fifo_inst (
    .sys_clk(sys_clk),
    .srst(srst),
    .inData(fifoIn),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .outData(fifoOut),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady)
  );

  // ==========================================================
  // Serial slave state machine
  assign rdTake = sclFall && !startSeen && !stopSeen &&
                  (((st_q == ST_ACK_HOLD) && rw_q) ||
                   (st_q == ST_RD_NEXT));

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= ST_IDLE;
      bitCnt_q <= 3'h0;
      shift_q <= 8'h00;
      rw_q <= 1'b0;
      isData_q <= 1'b0;
      sdaRel_q <= 1'b1;
    end else if (stopSeen) begin
      st_q <= ST_IDLE;
      sdaRel_q <= 1'b1;
    end else if (startSeen) begin
      st_q <= ST_ADDR;
      bitCnt_q <= 3'h0;
      sdaRel_q <= 1'b1;
    end else begin
      case (st_q)
        ST_ADDR: begin
          if (sclRise) begin
            shift_q <= rxByte;
            bitCnt_q <= bitCnt_q + 3'h1;
            if (bitCnt_q == 3'h7) begin
              rw_q <= sdaSync_q;
              isData_q <= rxAddr == DATA_ADDR;
              st_q <= addrHit ? ST_ACK_DRV : ST_IDLE;
            end
          end
        end
        ST_ACK_DRV: begin
          if (sclFall) begin
            sdaRel_q <= 1'b0;
            st_q <= ST_ACK_HOLD;
          end
        end
        ST_ACK_HOLD: begin
          if (sclFall) begin
            bitCnt_q <= 3'h0;
            if (rw_q) begin
              shift_q <= rdByte;
              sdaRel_q <= rdByte[7];
              st_q <= ST_RD_BYTE;
            end else begin
              sdaRel_q <= 1'b1;
              st_q <= ST_WR_BYTE;
            end
          end
        end
        ST_WR_BYTE: begin
          if (sclRise) begin
            shift_q <= rxByte;
            bitCnt_q <= bitCnt_q + 3'h1;
            // Full FIFO: no acknowledge, master sees a NACK
            if (bitCnt_q == 3'h7) begin
              st_q <= fifoInReady ? ST_ACK_DRV : ST_IDLE;
            end
          end
        end
        ST_RD_BYTE: begin
          if (sclFall) begin
            bitCnt_q <= bitCnt_q + 3'h1;
            if (bitCnt_q == 3'h7) begin
              sdaRel_q <= 1'b1;
              st_q <= ST_RD_ACK;
            end else begin
              sdaRel_q <= shift_q[6];
              shift_q <= {shift_q[6:0], 1'b0};
            end
          end
        end
        ST_RD_ACK: begin
          // Unacknowledged byte ends the read, SDA stays free
          if (sclRise) begin
            st_q <= sdaSync_q ? ST_IDLE : ST_RD_NEXT;
          end
        end
        ST_RD_NEXT: begin
          if (sclFall) begin
            bitCnt_q <= 3'h0;
            shift_q <= rdByte;
            sdaRel_q <= rdByte[7];
            st_q <= ST_RD_BYTE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
          sdaRel_q <= 1'b1;
        end
      endcase
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n = sdaRel_q;

  // ==========================================================
  // Read data selection
  always_comb begin
    rdByte = 8'h00;
    rdEp = lastCmd_q[3:0];
    if (inEpRange(lastCmd_q, `EPS_CMD_TXSTAT)) begin
      rdByte = txStat_q[rdEp];
    end else if (inEpRange(lastCmd_q, `EPS_CMD_EPCOND)) begin
      rdByte[`EPS_EC_SETUP] = epSetup_q[rdEp];
      rdByte[`EPS_EC_STALL] = epStall[rdEp];
      rdByte[`EPS_EC_TOGGLE] = epTog_q[rdEp];
      rdByte[`EPS_EC_FULL] = epFull[rdEp];
    end else if (lastCmd_q == `EPS_CMD_BUFFER) begin
      rdByte = bufMem_q[selEp_q][ptr_q];
    end
  end

  // ==========================================================
  // Command executor and buffer pointer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lastCmd_q <= `EPS_CMD_NONE;
      selEp_q <= 4'h0;
      ptr_q <= 4'h0;
    end else if (exCmd) begin
      lastCmd_q <= fifoOut.data;
      // Only endpoint select moves the pointer back
      if (fifoOut.data <= `EPS_LAST_EP) begin
        selEp_q <= fifoOut.data[3:0];
        ptr_q <= 4'h0;
      end
    end else if (exWrite ||
                 (rdTake && lastCmd_q == `EPS_CMD_BUFFER)) begin
      ptr_q <= ptr_q + 4'h1;
    end
  end

  assign selEndpoint = selEp_q;

  // ==========================================================
  // Endpoint buffers; no bound or direction check, by design
  always_ff @(posedge sys_clk) begin
    if (usbBuf.we) begin
      bufMem_q[usbBuf.ep][usbBuf.addr] <= usbBuf.wdata;
    end else if (exWrite) begin
      bufMem_q[selEp_q][ptr_q] <= fifoOut.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      usbBufRdData <= 8'h00;
    end else begin
      usbBufRdData <= bufMem_q[usbBuf.ep][usbBuf.addr];
    end
  end

  // ==========================================================
  // Transaction status, interrupt flags; a new event wins a clear
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int i = 0; i < `EPS_EP_SLOTS; i++) begin
        txStat_q[i] <= `EPS_TS_RESET;
      end
      pend_q <= '0;
      intFlag_q <= '0;
    end else begin
      if (rdTake && inEpRange(lastCmd_q, `EPS_CMD_TXSTAT)) begin
        txStat_q[rdEp] <= `EPS_TS_RESET;
        pend_q[rdEp] <= 1'b0;
        intFlag_q[rdEp] <= 1'b0;
      end
      if (rdTake && inEpRange(lastCmd_q, `EPS_CMD_EPCOND)) begin
        intFlag_q[rdEp] <= 1'b0;
      end
      if (usbEvt.valid) begin
        // Error field carries engine codes unchanged
        txStat_q[usbEvt.ep] <= {
          pend_q[usbEvt.ep],
          usbEvt.success && usbEvt.toggle,
          usbEvt.success && usbEvt.setup && !usbEvt.isIn,
          usbEvt.err,
          usbEvt.success
        };
        pend_q[usbEvt.ep] <= 1'b1;
        intFlag_q[usbEvt.ep] <= 1'b1;
      end
    end
  end

  assign epIntFlag = intFlag_q[`EPS_NUM_EP-1:0];

  // ==========================================================
  // Endpoint condition history
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      epSetup_q <= '0;
      epTog_q <= '0;
    end else if (usbEvt.valid && usbEvt.success) begin
      epTog_q[usbEvt.ep] <= usbEvt.toggle;
      if (!usbEvt.isIn) begin
        epSetup_q[usbEvt.ep] <= usbEvt.setup;
      end
    end
  end

endmodule : eps_buffer_access

// ===== bench/eps_buffer_access_asserts.sv
/*
  Port checker for the endpoint status and buffer access block.
  Assumes a bind to the top module and a single sys_clk domain.
*/
`include "eps_regs.svh"
module eps_buffer_access_asserts (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic scl_i,
  input wire logic sda_oe_n,
  input eps_pkg::eps_evt_type usbEvt,
  input eps_pkg::eps_bufreq_type usbBuf,
  input wire logic [7:0] usbBufRdData,
  input wire logic [`EPS_NUM_EP-1:0] epIntFlag,
  input wire logic [3:0] selEndpoint
);
  timeunit 1ns;
  timeprecision 1ps;
  import eps_pkg::*;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // ==========================================================
  // Checks
  a_reset_idle: assert property (
    disable iff (1'b0) srst |=> sda_oe_n && epIntFlag == 14'h0000 &&
    selEndpoint == 4'h0) else $error("outputs not idle in reset");
  a_evt_flag: assert property (
    usbEvt.valid && usbEvt.ep < 4'hE |=> epIntFlag[$past(usbEvt.ep)])
    else $error("event did not raise its flag");
  a_flag_cause: assert property (
    !usbEvt.valid |=> (epIntFlag & ~$past(epIntFlag)) == 14'h0000)
    else $error("flag rose without event");
  // Clears come only from a byte load, which follows an SCL fall
  a_clear_scl_low: assert property (
    ($past(epIntFlag) & ~epIntFlag) != 14'h0000 |-> !scl_i)
    else $error("flag cleared outside a byte load");
  a_one_clear: assert property (
    $onehot0($past(epIntFlag) & ~epIntFlag))
    else $error("several flags cleared at once");
  a_sel_range: assert property (
    selEndpoint <= 4'hD) else $error("selected endpoint out of range");
  a_oe_scl_low: assert property (
    $changed(sda_oe_n) |-> !scl_i)
    else $error("SDA drive changed while SCL high");
  a_buf_rdback: assert property (
    usbBuf.we ##1 (!usbBuf.we && usbBuf.ep == $past(usbBuf.ep) &&
    usbBuf.addr == $past(usbBuf.addr)) |=>
    usbBufRdData == $past(usbBuf.wdata, 2))
    else $error("buffer read back differs from write");
endmodule : eps_buffer_access_asserts

// ===== bench/eps_i2c_master.sv
/*
  Behavioural serial bus master: drives SCL, pulls or releases SDA.
  Assumes the bench resolves the open-drain SDA wire with a pull-up.
*/
module eps_i2c_master (
  input wire logic sys_clk,
  input wire logic sdaWire,
  output logic scl,
  output logic sdaRel
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl = 1'b1;
    sdaRel = 1'b1;
  end

  // ==========================================================
  // Bus phases of 4 sys_clk; SDA moves while SCL is high only in start and stop
  task automatic step(input logic c, input logic d);
    scl <= c;
    sdaRel <= d;
    repeat (4) @(posedge sys_clk);
  endtask : step

  task automatic bitx(input logic d, output logic s);
    step(1'b0, sdaRel);
    step(1'b0, d);
    step(1'b1, d);
    s = sdaWire;
    step(1'b1, d);
  endtask : bitx

  // Also serves as repeated start
  task automatic start();
    @(posedge sys_clk);
    step(1'b0, sdaRel);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask : start

  task automatic stop();
    step(1'b0, sdaRel);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : stop

  task automatic xfer(input logic [7:0] w, input logic ackOut,
                      output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(w[i], r[i]);
    end
    bitx(ackOut, s);
    ack = !s;
  endtask : xfer
endmodule : eps_i2c_master

// ===== bench/tb_eps_buffer_access.sv
/*
  Self-checking bench for the endpoint status and buffer access block.
  Assumes the serial master model and the port checker beside it.
*/
`include "eps_regs.svh"
module tb_eps_buffer_access;
  timeunit 1ns;
  timeprecision 1ps;
  import eps_pkg::*;

  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic scl, sdaRel, sdaWire, sda_o, sda_oe_n;
  eps_evt_type usbEvt = '0;
  eps_bufreq_type usbBuf = '0;
  logic [`EPS_NUM_EP-1:0] epStall = '0, epFull = '0, epIntFlag;
  logic [7:0] usbBufRdData;
  logic [3:0] selEndpoint;
  logic [7:0] rb [4];
  int fails = 0, total_checks = 0;

  always #2.5 sys_clk = ~sys_clk;
  // Open drain with pull-up
  assign sdaWire = sdaRel & (sda_oe_n | sda_o);

  eps_buffer_access eps_buffer_access_inst (.sys_clk(sys_clk),
    .srst(srst), .scl_i(scl), .sda_i(sdaWire), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .usbEvt(usbEvt), .epStall(epStall),
    .epFull(epFull), .usbBuf(usbBuf), .usbBufRdData(usbBufRdData),
    .epIntFlag(epIntFlag), .selEndpoint(selEndpoint));
  eps_i2c_master eps_i2c_master_inst (.sys_clk(sys_clk),
    .sdaWire(sdaWire), .scl(scl), .sdaRel(sdaRel));

  // ==========================================================
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [6:0] ad, input int n,
                    input logic [31:0] w);
    logic [7:0] r;
    logic a;
    eps_i2c_master_inst.start();
    eps_i2c_master_inst.xfer({ad, 1'b0}, 1'b1, r, a);
    chk({7'h00, a}, 8'h01);
    for (int i = n - 1; i >= 0; i--) begin
      eps_i2c_master_inst.xfer(w[8*i+:8], 1'b1, r, a);
      chk({7'h00, a}, 8'h01);
    end
    eps_i2c_master_inst.stop();
  endtask : wr

  task automatic cmd(input logic [7:0] c);
    wr(`EPS_CMD_ADDR, 1, {24'h000000, c});
  endtask : cmd

  task automatic rd(input int n);
    logic [7:0] r;
    logic a;
    eps_i2c_master_inst.start();
    eps_i2c_master_inst.xfer({`EPS_DATA_ADDR, 1'b1}, 1'b1, r, a);
    chk({7'h00, a}, 8'h01);
    for (int i = 0; i < n; i++) begin
      eps_i2c_master_inst.xfer(8'hFF, i == n - 1, rb[i], a);
    end
    eps_i2c_master_inst.stop();
  endtask : rd

  task automatic evt(input logic [3:0] ep, input logic isIn, s, su, tg,
                     input eps_err_type e);
    @(posedge sys_clk);
    usbEvt <= '{1'b1, ep, isIn, s, su, tg, e};
    @(posedge sys_clk);
    usbEvt.valid <= 1'b0;
    #1;
  endtask : evt

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] r;
    logic a;
    chk({7'h00, sda_oe_n}, 8'h01);
    chk({3'h0, |epIntFlag, selEndpoint}, 8'h00);
    eps_i2c_master_inst.start();
    eps_i2c_master_inst.xfer({`EPS_CMD_ADDR, 1'b1}, 1'b1, r, a);
    chk({7'h00, a}, 8'h00);
    eps_i2c_master_inst.stop();
    cmd(8'h43);
    rd(1);
    chk(rb[0], 8'h00);
    cmd(8'h83);
    rd(1);
    chk(rb[0], 8'h00);
  endtask : t_reset

  task automatic t_txstat();
    evt(4'h2, 1'b0, 1'b1, 1'b1, 1'b1, ERR_NONE);
    chk({7'h00, epIntFlag[2]}, 8'h01);
    cmd(8'h42);
    rd(1);
    chk(rb[0], 8'h61);
    chk({7'h00, epIntFlag[2]}, 8'h00);
    rd(1);
    chk(rb[0], 8'h00);
  endtask : t_txstat

  task automatic t_errors();
    evt(4'h5, 1'b1, 1'b1, 1'b1, 1'b1, ERR_NONE);
    cmd(8'h45);
    rd(1);
    chk(rb[0], 8'h41);
    for (int c = 0; c < 16; c++) begin
      if (c == 12 || c == 14) continue;
      evt(4'h5, 1'b1, 1'b1, 1'b0, 1'b0, ERR_NONE);
      evt(4'h5, 1'b0, 1'b0, 1'b1, 1'b1, eps_err_type'(c[3:0]));
      rd(1);
      chk(rb[0], {3'b100, c[3:0], 1'b0});
      chk({4'h0, rb[0][4:1]}, {4'h0, c[3:0]});
      chk({7'h00, rb[0][5]}, 8'h00);
    end
  endtask : t_errors

  task automatic t_cond();
    @(posedge sys_clk);
    epStall[4] <= 1'b1;
    epFull[4] <= 1'b1;
    evt(4'h4, 1'b0, 1'b1, 1'b1, 1'b1, ERR_NONE);
    cmd(8'h84);
    rd(1);
    chk(rb[0], 8'h3C);
    chk({7'h00, epIntFlag[4]}, 8'h00);
    epStall[4] <= 1'b0;
    epFull[4] <= 1'b0;
    rd(1);
    chk(rb[0], 8'h14);
  endtask : t_cond

  task automatic t_buffer();
    logic [31:0] w;
    logic [31:0] e;
    w = 32'h0002A55A;
    e = 32'h0002C33C;
    cmd(8'h03);
    chk({4'h0, selEndpoint}, 8'h03);
    cmd(8'hF0);
    wr(`EPS_DATA_ADDR, 4, w);
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      usbBuf <= '{1'b1, 4'h6, k[3:0], e[8*(3-k)+:8]};
      @(posedge sys_clk);
      usbBuf.we <= 1'b0;
      @(posedge sys_clk);
      usbBuf.ep <= 4'h3;
      #1;
      chk(usbBufRdData, e[8*(3-k)+:8]);
      @(posedge sys_clk);
      #1;
      chk(usbBufRdData, w[8*(3-k)+:8]);
    end
    cmd(8'h06);
    cmd(8'hF0);
    rd(2);
    chk(rb[0], e[31:24]);
    chk(rb[1], e[23:16]);
    cmd(8'h46);
    cmd(8'hF0);
    rd(2);
    chk(rb[0], e[15:8]);
    chk(rb[1], e[7:0]);
  endtask : t_buffer

  task automatic end_of_test();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_txstat();
    t_errors();
    t_cond();
    t_buffer();
    end_of_test();
  end

  // Run takes about 60 us; margin stays under 100k cycles
  initial begin
    #400000;
    fails++;
    end_of_test();
  end
endmodule : tb_eps_buffer_access

bind eps_buffer_access eps_buffer_access_asserts
  eps_buffer_access_asserts_inst (.sys_clk(sys_clk), .srst(srst),
  .scl_i(scl_i), .sda_oe_n(sda_oe_n), .usbEvt(usbEvt), .usbBuf(usbBuf),
  .usbBufRdData(usbBufRdData), .epIntFlag(epIntFlag),
  .selEndpoint(selEndpoint));
